//--- common/pwmuot_pkg.sv
package pwmuot_pkg;

  // ==========================================================================
  // Widths
  localparam int unsigned CNT_W = 16;

  // ==========================================================================
  // Output control register fields
  localparam int unsigned OC_SYNC_BIT   = 0;
  localparam int unsigned OC_LVL_LO     = 0;
  localparam int unsigned OC_LVL_HI     = 1;
  localparam int unsigned OC_LOW_EN_BIT = 8;
  localparam int unsigned OC_HIGH_EN_BIT = 9;
  localparam int unsigned OC_MODE_LO    = 10;
  localparam int unsigned OC_MODE_HI    = 11;

  // ==========================================================================
  // Channel control register fields
  localparam int unsigned CC_IMM_BIT    = 0;
  localparam int unsigned CC_MDC_BIT    = 8;
  localparam int unsigned CC_ITB_BIT    = 9;

  // ==========================================================================
  // Master time-base control and trigger control fields
  localparam int unsigned MT_EN_BIT     = 15;
  localparam int unsigned TC_DIV_LO     = 12;
  localparam int unsigned TC_DIV_HI     = 15;
  localparam int unsigned TC_STRT_LO    = 0;
  localparam int unsigned TC_STRT_HI    = 5;

  // ==========================================================================
  // Output modes
  typedef enum logic [1:0] {
    PWMUOT_MODE_COMP = 2'h0,
    PWMUOT_MODE_RED  = 2'h1,
    PWMUOT_MODE_PP   = 2'h2,
    PWMUOT_MODE_IND  = 2'h3
  } pwmuot_mode_e;

  // ==========================================================================
  // Reset values and counts
  localparam logic [15:0]      CTRL_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [15:0] output_ctrl_reg;
    logic [15:0] channel_ctrl_reg;
    logic [15:0] master_timebase_ctrl_reg;
    logic [15:0] trigger_ctrl_reg;
  } pwmuot_ctrl_s;

  typedef struct packed {
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] channel_duty_reg;
    logic [CNT_W-1:0] master_duty;
    logic [CNT_W-1:0] phase_offset_reg;
    logic [CNT_W-1:0] dead_time_reg;
    logic [CNT_W-1:0] primary_trigger_compare;
    logic [CNT_W-1:0] secondary_trigger_compare;
  } pwmuot_values_s;

  typedef struct packed {
    logic high_side_output;
    logic low_side_output;
  } pwmuot_out_s;

endpackage

//--- verilog/pwmuot_trig.sv
`timescale 1ns/10ps
module pwmuot_trig
  import pwmuot_pkg::*;
#(
  parameter int unsigned DIV_W  = 4,
  parameter int unsigned STRT_W = 6
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  input  wire logic              run,
  input  wire logic              match,
  input  wire logic [DIV_W-1:0]  divider,
  input  wire logic [STRT_W-1:0] start_count,
  output logic                   trig
);

  // ==========================================================================
  // Postscaler: skip start_count matches, then fire every divider+1 matches
  logic [STRT_W-1:0] skip_reg;
  logic [STRT_W-1:0] skip_next;
  logic [DIV_W-1:0]  div_reg;
  logic [DIV_W-1:0]  div_next;
  logic              trig_reg;
  logic              trig_next;
  logic              armed_reg;
  logic              armed_next;

  always_comb begin
    skip_next  = skip_reg;
    div_next   = div_reg;
    trig_next  = 1'b0;
    armed_next = armed_reg;
    if (!run) begin
      skip_next  = '0;
      div_next   = '0;
      armed_next = 1'b0;
    end else if (match) begin
      if (!armed_reg && skip_reg < start_count) begin
        skip_next = skip_reg + 1'b1;
      end else begin
        armed_next = 1'b1;
        if (div_reg == '0) begin
          trig_next = 1'b1;
        end
        if (div_reg >= divider) begin
          div_next = '0;
        end else begin
          div_next = div_reg + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      skip_reg  <= '0;
      div_reg   <= '0;
      trig_reg  <= 1'b0;
      armed_reg <= 1'b0;
    end else if (clk_en) begin
      skip_reg  <= skip_next;
      div_reg   <= div_next;
      trig_reg  <= trig_next;
      armed_reg <= armed_next;
    end
  end

  assign trig = trig_reg;

endmodule

//--- verilog/pwmuot_channel.sv
`timescale 1ns/10ps
// What this block does
// - Override forces outputs to override level
// - Override off resumes normal duty waveform
// - Sync bit zero applies override immediately
// - Immediate-update bit makes duty writes instant
// - Phase change keeps dead time, master base
// - Triggers fire on time-base compare match
// - Four-bit divider, six-bit start count fields
// - First trigger instance placed exactly
// - Mode codes: redundant 01, push-pull 10
// - Bit 8 selects channel or master duty
// - Duty to zero yields no glitch
// - Separate high and low override enables
module pwmuot_channel
  import pwmuot_pkg::*;
#(
  parameter int unsigned W = CNT_W
) (
  input  wire logic           clk,
  input  wire logic           reset_n,
  input  wire logic           clk_en,
  input  wire pwmuot_ctrl_s   ctrl,
  input  wire pwmuot_values_s vals,
  output pwmuot_out_s         pwm_out,
  output logic                primary_trig,
  output logic                secondary_trig,
  output logic                period_boundary
);

  // ==========================================================================
  // Control decode
  logic         run;
  logic         imm;
  logic         use_master;
  logic         sync_ovr;
  logic         ovr_h;
  logic         ovr_l;
  pwmuot_mode_e mode;
  logic [W-1:0] duty_src;

  assign run        = ctrl.master_timebase_ctrl_reg[MT_EN_BIT];
  assign imm        = ctrl.channel_ctrl_reg[CC_IMM_BIT];
  assign use_master = ctrl.channel_ctrl_reg[CC_MDC_BIT];
  assign sync_ovr   = ctrl.output_ctrl_reg[OC_SYNC_BIT];
  assign ovr_h      = ctrl.output_ctrl_reg[OC_HIGH_EN_BIT];
  assign ovr_l      = ctrl.output_ctrl_reg[OC_LOW_EN_BIT];
  assign mode       = pwmuot_mode_e'(ctrl.output_ctrl_reg[OC_MODE_HI:OC_MODE_LO]);
  assign duty_src   = use_master ? vals.master_duty : vals.channel_duty_reg;

  // ==========================================================================
  // Time base, active comparators, override latch
  logic [W-1:0] tb_reg;
  logic [W-1:0] tb_next;
  logic [W-1:0] duty_reg;
  logic [W-1:0] duty_next;
  logic [W-1:0] phase_reg;
  logic [W-1:0] phase_next;
  logic [3:0]   ovr_reg;
  logic [3:0]   ovr_next;
  logic         boundary;

  assign boundary = run && (tb_reg >= vals.period);

  always_comb begin
    tb_next    = tb_reg;
    duty_next  = duty_reg;
    phase_next = phase_reg;
    ovr_next   = ovr_reg;
    if (!run) begin
      tb_next    = CNT_ZERO;
      duty_next  = duty_src;
      phase_next = vals.phase_offset_reg;
    end else if (boundary) begin
      tb_next    = CNT_ZERO;
      duty_next  = duty_src;
      phase_next = vals.phase_offset_reg;
    end else begin
      tb_next = tb_reg + CNT_ONE;
    end
    if (imm) begin
      duty_next  = duty_src;
      phase_next = vals.phase_offset_reg;
    end
    if (!sync_ovr || boundary || !run) begin
      ovr_next = {ovr_h, ovr_l, ctrl.output_ctrl_reg[OC_LVL_HI:OC_LVL_LO]};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tb_reg    <= CNT_ZERO;
      duty_reg  <= CNT_ZERO;
      phase_reg <= CNT_ZERO;
      ovr_reg   <= '0;
    end else if (clk_en) begin
      tb_reg    <= tb_next;
      duty_reg  <= duty_next;
      phase_reg <= phase_next;
      ovr_reg   <= ovr_next;
    end
  end

  // ==========================================================================
  // Raw waveform: high from phase for duty counts; zero duty gives none
  logic [W:0] end_pt;
  logic       raw;

  assign end_pt = {1'b0, phase_reg} + {1'b0, duty_reg};
  assign raw    = run && (duty_reg != CNT_ZERO) && (tb_reg >= phase_reg) &&
                  ({1'b0, tb_reg} < end_pt);

  // ==========================================================================
  // Dead time: in complementary mode any change of raw holds both sides off for the count
  logic         raw_q_reg;
  logic         raw_q_next;
  logic [W-1:0] dt_reg;
  logic [W-1:0] dt_next;
  logic         pp_reg;
  logic         pp_next;
  logic         h_reg;
  logic         h_next;
  logic         l_reg;
  logic         l_next;
  logic         h_w;
  logic         l_w;

  always_comb begin
    raw_q_next = raw;
    dt_next    = dt_reg;
    pp_next    = pp_reg;
    if (raw != raw_q_reg) begin
      dt_next = vals.dead_time_reg;
    end else if (dt_reg != CNT_ZERO) begin
      dt_next = dt_reg - CNT_ONE;
    end
    if (boundary) begin
      pp_next = ~pp_reg;
    end
    case (mode)
      PWMUOT_MODE_RED: begin
        h_w = raw;
        l_w = raw;
      end
      PWMUOT_MODE_PP: begin
        h_w = raw && !pp_reg;
        l_w = raw && pp_reg;
      end
      PWMUOT_MODE_IND: begin
        h_w = raw;
        l_w = 1'b0;
      end
      default: begin
        h_w = raw && (dt_reg == CNT_ZERO) && (raw == raw_q_reg);
        l_w = !raw && run && (dt_reg == CNT_ZERO) && (raw == raw_q_reg);
      end
    endcase
    h_next = ovr_reg[3] ? ovr_reg[1] : h_w;
    l_next = ovr_reg[2] ? ovr_reg[0] : l_w;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      raw_q_reg <= 1'b0;
      dt_reg    <= CNT_ZERO;
      pp_reg    <= 1'b0;
      h_reg     <= 1'b0;
      l_reg     <= 1'b0;
    end else if (clk_en) begin
      raw_q_reg <= raw_q_next;
      dt_reg    <= dt_next;
      pp_reg    <= pp_next;
      h_reg     <= h_next;
      l_reg     <= l_next;
    end
  end

  assign pwm_out.high_side_output = h_reg;
  assign pwm_out.low_side_output  = l_reg;
  assign period_boundary          = boundary;

  // ==========================================================================
  // Triggers
  logic pri_match;
  logic sec_match;

  assign pri_match = run && (tb_reg == vals.primary_trigger_compare);
  assign sec_match = run && (tb_reg == vals.secondary_trigger_compare);

  pwmuot_trig u_pri (
    .clk         (clk),
    .reset_n     (reset_n),
    .clk_en      (clk_en),
    .run         (run),
    .match       (pri_match),
    .divider     (ctrl.trigger_ctrl_reg[TC_DIV_HI:TC_DIV_LO]),
    .start_count (ctrl.trigger_ctrl_reg[TC_STRT_HI:TC_STRT_LO]),
    .trig        (primary_trig)
  );

  pwmuot_trig u_sec (
    .clk         (clk),
    .reset_n     (reset_n),
    .clk_en      (clk_en),
    .run         (run),
    .match       (sec_match),
    .divider     (ctrl.trigger_ctrl_reg[TC_DIV_HI:TC_DIV_LO]),
    .start_count (ctrl.trigger_ctrl_reg[TC_STRT_HI:TC_STRT_LO]),
    .trig        (secondary_trig)
  );

endmodule

//--- verif/pwmuot_chk_sva.sv
`timescale 1ns/10ps
// ==========
// Port checker
module pwmuot_chk
  import pwmuot_pkg::*;
(
  input wire logic           clk,
  input wire logic           reset_n,
  input wire logic           clk_en,
  input wire pwmuot_ctrl_s   ctrl,
  input wire pwmuot_values_s vals,
  input wire pwmuot_out_s    pwm_out,
  input wire logic           primary_trig,
  input wire logic           secondary_trig,
  input wire logic           period_boundary
);
  logic [15:0] cnt_reg, bl_reg, zc_reg, cnt_next, bl_next, zc_next;
  logic        seen_reg, seen_next;
  wire  [15:0] oc = ctrl.output_ctrl_reg;
  wire         h = pwm_out.high_side_output;
  wire         l = pwm_out.low_side_output;
  wire         comp = oc[11:8] == 4'h0 && oc[1:0] != 2'h3;
  wire         tq = ctrl.master_timebase_ctrl_reg[15];
  wire         dz = (ctrl.channel_ctrl_reg[8] ? vals.master_duty : vals.channel_duty_reg) == 16'h0;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  always_comb begin
    cnt_next  = (period_boundary || !ctrl.master_timebase_ctrl_reg[15]) ? 16'h0 : cnt_reg + 16'h1;
    seen_next = (seen_reg | period_boundary) & ctrl.master_timebase_ctrl_reg[15];
    bl_next   = (h | l) ? 16'h0 : bl_reg + 16'h1;
    zc_next   = (dz && oc[9:8] == 2'h0) ? zc_reg + 16'h1 : 16'h0;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg  <= 16'h0;
      bl_reg   <= 16'h0;
      zc_reg   <= 16'h0;
      seen_reg <= 1'b0;
    end else if (clk_en) begin
      cnt_reg  <= cnt_next;
      bl_reg   <= bl_next;
      zc_reg   <= zc_next;
      seen_reg <= seen_next;
    end
  end
  sequence s_forced;
    clk_en && oc[9:8] == 2'h3 && !oc[0];
  endsequence
  a_period_wrap: assert property (period_boundary && seen_reg && clk_en |-> cnt_reg == vals.period)
    else $error("time base wrap off");
  a_trig_primary_time: assert property (
    primary_trig && tq && vals.primary_trigger_compare < vals.period
    |-> cnt_reg == vals.primary_trigger_compare + 16'h1) else $error("primary trigger misplaced");
  a_trig_second_time: assert property (
    secondary_trig && tq && vals.secondary_trigger_compare < vals.period
    |-> cnt_reg == vals.secondary_trigger_compare + 16'h1) else $error("secondary trigger misplaced");
  a_trig_single_pulse: assert property (primary_trig && clk_en && vals.period != 16'h0 |=> !primary_trig)
    else $error("trigger pulse too long");
  a_dead_time_gap: assert property (
    ($rose(h) || $rose(l)) && comp && $past(comp, 2) && seen_reg |-> bl_reg > vals.dead_time_reg)
    else $error("dead time short");
  a_no_shoot_through: assert property (comp && $past(comp) |-> !(h && l))
    else $error("both outputs high");
  a_force_unsync_level: assert property (s_forced [*3] |-> h == oc[1] && !l)
    else $error("override level not applied");
  a_zero_duty_quiet: assert property (
    oc[11:10] != 2'h0 && zc_reg > {vals.period[14:0], 1'b0} + 16'h4 |-> !h && (oc[11:10] == 2'h3 || !l))
    else $error("pulse with zero duty");
  a_freeze_hold: assert property (!clk_en |=> $stable(pwm_out))
    else $error("outputs moved while frozen");
endmodule

//--- verif/pwmuot_gate.sv
`timescale 1ns/10ps
// ==========
// Gate driver input model, counts high side pulses
module pwmuot_gate (
  input  wire logic clk,
  input  wire logic gate_hi,
  input  wire logic gate_lo,
  output int        hi_edges
);
  logic hi_d = 1'b0;
  initial hi_edges = 0;
  always @(posedge clk) begin
    hi_d <= gate_hi;
    if (gate_hi && !hi_d)
      hi_edges <= hi_edges + 1;
  end
endmodule

//--- verif/tb.sv
`timescale 1ns/10ps
// ==========
// Bench
module tb
  import pwmuot_pkg::*;
;
  logic           clk = 1'b0;
  logic           reset_n = 1'b0;
  logic           clk_en = 1'b1;
  bit             jit = 1'b0;
  pwmuot_ctrl_s   ctrl = '0;
  pwmuot_values_s vals = '0;
  pwmuot_out_s    pwm_out;
  logic           primary_trig, secondary_trig, period_boundary;
  int             num_errors = 0, n_tests = 0, hi_edges, np, ns, nb, d, s, m;
  pwmuot_channel DUT (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .ctrl(ctrl), .vals(vals),
    .pwm_out(pwm_out), .primary_trig(primary_trig), .secondary_trig(secondary_trig),
    .period_boundary(period_boundary));
  pwmuot_gate u_gate (.clk(clk), .gate_hi(pwm_out.high_side_output), .gate_lo(pwm_out.low_side_output),
    .hi_edges(hi_edges));
  initial forever #10 clk = ~clk;
  always @(posedge clk) clk_en <= jit ? 1'($urandom % 8 != 0) : 1'b1;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic setup(input logic [1:0] md, input logic [3:0] dv, input logic [5:0] st, input logic im);
    logic [15:0] p;
    @(posedge clk);
    ctrl.master_timebase_ctrl_reg <= 16'h0;
    p = 16'h14 + 16'($urandom % 20);
    vals <= '{p, 16'h1 + 16'($urandom % 19), 16'h5, 16'($urandom % 4), 16'h2 + 16'($urandom % 3),
      16'h8 + 16'($urandom % 12), 16'h8};
    ctrl.output_ctrl_reg <= {4'h0, md, 10'h0};
    ctrl.channel_ctrl_reg <= {15'h0, im};
    ctrl.trigger_ctrl_reg <= {dv, 6'h0, st};
    @(posedge clk);
    ctrl.master_timebase_ctrl_reg <= 16'h8000;
  endtask
  task automatic run(input int k);
    int t;
    np = 0;
    ns = 0;
    nb = 0;
    t = 0;
    while (nb < k) begin
      @(negedge clk);
      if (clk_en) begin
        np += primary_trig;
        ns += secondary_trig;
        nb += period_boundary;
      end
      if (++t > 20000) begin
        num_errors++;
        end_of_test();
      end
    end
  endtask
  task automatic force_out(input logic [15:0] v);
    for (int k = 0; k < 100 && !period_boundary; k++)
      @(negedge clk);
    if (!period_boundary)
      num_errors++;
    @(posedge clk);
    ctrl.output_ctrl_reg <= v;
    repeat (3) @(posedge clk);
    #1;
  endtask
  initial begin
    m = $urandom(85);
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      d = i == 0 ? 0 : (i == 3 ? 15 : $urandom % 16);
      s = i == 0 ? 0 : (i == 3 ? 63 : $urandom % 8);
      setup(i[1:0], d[3:0], s[5:0], 1'($urandom));
      jit = i > 0;
      run(90);
      jit = 1'b0;
      m = 90 > s ? (89 - s) / (d + 1) + 1 : 0;
      check(np[15:0], m[15:0]);
      check(ns[15:0], m[15:0]);
    end
    for (int j = 1; j < 3; j++) begin
      setup(j[1:0], 4'h0, 6'h0, 1'b0);
      run(2);
      m = hi_edges;
      run(2);
      check(16'(hi_edges > m), 16'h1);
      @(posedge clk);
      vals.channel_duty_reg <= 16'h0;
      run(3);
      m = hi_edges;
      run(3);
      check(16'(hi_edges - m), 16'h0);
    end
    setup(2'h0, 4'h0, 6'h0, 1'b1);
    run(1);
    @(posedge clk);
    vals.channel_duty_reg <= 16'h0;
    m = hi_edges;
    run(1);
    check(16'(hi_edges - m), 16'h0);
    @(posedge clk);
    vals.channel_duty_reg <= 16'h5;
    run(1);
    force_out(16'h0202);
    check(16'(pwm_out.high_side_output), 16'h1);
    force_out(16'h0300);
    check(16'(pwm_out), 16'h0);
    force_out(16'h0000);
    m = hi_edges;
    run(3);
    check(16'(hi_edges > m), 16'h1);
    end_of_test();
  end
endmodule
bind pwmuot_channel pwmuot_chk u_chk (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .ctrl(ctrl), .vals(vals),
  .pwm_out(pwm_out), .primary_trig(primary_trig), .secondary_trig(secondary_trig),
  .period_boundary(period_boundary));
